// ---- hw/tic_pkg.sv ----
// constants and types for the interpolating time interval counter
package tic_pkg;

  // ****************************************
  // clock and resolution
  // ****************************************
  localparam longint CLK_HZ = 10_000_000;
  // wider than 32 bits, so the literal is sized
  localparam longint PS_PER_S = 64'h000000E8D4A51000;
  localparam longint CLK_PERIOD_PS = PS_PER_S / CLK_HZ;
  localparam int STRETCH = 1000;
  // 100 ps: the counter behaves as if clocked STRETCH times faster
  localparam longint RESOLUTION_PS = CLK_PERIOD_PS / STRETCH;

  // ****************************************
  // widths and limits
  // ****************************************
  localparam int COARSE_W = 24;
  localparam int FINE_W = 11;
  localparam int RES_W = 40;
  localparam int ACC_W = 48;
  localparam int AVG_CNT_W = 8;
  // intervals averaged; resolution improves as one count / sqrt(AVG_N)
  localparam int AVG_N = 100;
  localparam logic [AVG_CNT_W-1:0] AVG_LAST = 8'h63;
  localparam logic [COARSE_W-1:0] COARSE_MAX = 24'hFFFFFF;
  localparam logic [FINE_W-1:0] FINE_MAX = 11'h7FF;
  localparam logic [FINE_W-1:0] FINE_ZERO = 11'h000;
  localparam logic [COARSE_W-1:0] COARSE_ZERO = 24'h000000;
  localparam logic [ACC_W-1:0] ACC_ZERO = 48'h000000000000;
  localparam logic [RES_W-1:0] RES_ZERO = 40'h0000000000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_GATE,
    ST_FINE,
    ST_CALC
  } tic_state_t;

  typedef struct packed {
    logic coarse_neg;
    logic [COARSE_W-1:0] coarse;
    logic [FINE_W-1:0] start_fine;
    logic [FINE_W-1:0] stop_fine;
  } tic_meas_t;

endpackage

// ---- hw/tic_gate_sync.sv ----
// gate synchronizer: one full clock period count pulse per gated edge
`timescale 1ns/1ps
module tic_gate_sync (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic gate_i,
  output logic count_o
);

  // full period pulse
  // the pulse is rebuilt from the clock edge itself, so the chain never
  // sees a sliver shorter than a period
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_o <= 1'b0;
    end else begin
      count_o <= gate_i;
    end
  end

endmodule

// ---- hw/tic_top.sv ----
// interpolating time interval counter with averaging mode
//
// Contract
// - averaging mode accumulates the coarse parts of many interval results and averages them.
// - the averaged count is a parameter, resolution one count over root N.
// - in averaging the synchronizer always feeds the decade counter chain.
// - each clock edge seen while the gate is open counts once.
// - each counted edge becomes a pulse one full clock period long.
// - the start residue is stretched by 1000 by the interpolator.
// - clocks are counted during the start discharge as the start fine count.
// - the stop residue is stretched and counted the same way.
// - the coarse count of whole clocks runs between start and stop.
// - result is coarse times 1000 plus start fine minus stop fine.
// - single events are measured with no repetition needed.
// - zero and negative intervals are supported.
// - sign and magnitude of the result are reported.
// - a 10 MHz reference gives 100 ps per result unit.
`timescale 1ns/1ps
module tic_top (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic START_I,
  input wire logic STOP_I,
  input wire logic START_DISCH_I,
  input wire logic STOP_DISCH_I,
  input wire logic AVG_MODE_I,
  output logic START_ARM_O,
  output logic STOP_ARM_O,
  output logic BUSY_O,
  output logic DONE_O,
  output logic signed [tic_pkg::RES_W-1:0] RESULT_O,
  output logic RESULT_NEG_O,
  output logic [tic_pkg::RES_W-1:0] RESULT_MAG_O,
  output logic AVG_DONE_O,
  output logic signed [tic_pkg::RES_W-1:0] AVG_RESULT_O
);

  // ****************************************
  // functions
  // ****************************************
  // combine counts
  function automatic logic signed [tic_pkg::RES_W-1:0] combine(
    input tic_pkg::tic_meas_t m);
    logic signed [tic_pkg::RES_W-1:0] c;
    c = $signed(tic_pkg::RES_W'(m.coarse))
      * $signed(tic_pkg::RES_W'(tic_pkg::STRETCH));
    // stop first gives a negative coarse part
    if (m.coarse_neg) begin
      c = -c;
    end
    return c + $signed(tic_pkg::RES_W'(m.start_fine))
      - $signed(tic_pkg::RES_W'(m.stop_fine));
  endfunction

  function automatic logic [tic_pkg::FINE_W-1:0] fine_inc(
    input logic [tic_pkg::FINE_W-1:0] v);
    return (v == tic_pkg::FINE_MAX) ? v : v + 11'h001;
  endfunction

  // ****************************************
  // input synchronizers
  // ****************************************
  logic [1:0] start_ff;
  logic [1:0] stop_ff;
  logic [1:0] sdis_ff;
  logic [1:0] pdis_ff;
  logic [1:0] avg_ff;
  logic start_prev;
  logic stop_prev;
  logic sdis_prev;
  logic pdis_prev;

  // two stages, only bit 1 is read downstream
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      start_ff <= 2'h0;
      stop_ff <= 2'h0;
      sdis_ff <= 2'h0;
      pdis_ff <= 2'h0;
      avg_ff <= 2'h0;
    end else begin
      start_ff <= {start_ff[0], START_I};
      stop_ff <= {stop_ff[0], STOP_I};
      sdis_ff <= {sdis_ff[0], START_DISCH_I};
      pdis_ff <= {pdis_ff[0], STOP_DISCH_I};
      avg_ff <= {avg_ff[0], AVG_MODE_I};
    end
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      start_prev <= 1'b0;
      stop_prev <= 1'b0;
      sdis_prev <= 1'b0;
      pdis_prev <= 1'b0;
    end else begin
      start_prev <= start_ff[1];
      stop_prev <= stop_ff[1];
      sdis_prev <= sdis_ff[1];
      pdis_prev <= pdis_ff[1];
    end
  end

  logic start_rise;
  logic stop_rise;
  assign start_rise = start_ff[1] & ~start_prev;
  assign stop_rise = stop_ff[1] & ~stop_prev;

  // ****************************************
  // sequencing
  // ****************************************
  tic_pkg::tic_state_t state;
  tic_pkg::tic_meas_t meas;
  logic coarse_neg;
  logic [tic_pkg::COARSE_W-1:0] coarse_count;
  logic [tic_pkg::FINE_W-1:0] start_fine_count;
  logic [tic_pkg::FINE_W-1:0] stop_fine_count;
  logic start_fdone;
  logic stop_fdone;
  logic gate;
  logic count_pulse;
  logic fine_done;

  assign gate = (state == tic_pkg::ST_GATE);
  assign fine_done = start_fdone & stop_fdone & ~count_pulse;
  // one process per field; the struct only carries them together
  assign meas = {coarse_neg, coarse_count,
                 start_fine_count, stop_fine_count};

  // each single start/stop pair is a full measurement
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state <= tic_pkg::ST_IDLE;
      coarse_neg <= 1'b0;
    end else begin
      unique case (state)
        tic_pkg::ST_IDLE: begin
          if (start_rise | stop_rise) begin
            coarse_neg <= stop_rise & ~start_rise;
            // coincident events skip the gate: zero coarse count
            state <= (start_rise & stop_rise) ?
              tic_pkg::ST_FINE : tic_pkg::ST_GATE;
          end
        end
        tic_pkg::ST_GATE: begin
          if (meas.coarse_neg ? start_rise : stop_rise) begin
            state <= tic_pkg::ST_FINE;
          end
        end
        tic_pkg::ST_FINE: begin
          if (fine_done) begin
            state <= tic_pkg::ST_CALC;
          end
        end
        tic_pkg::ST_CALC: begin
          state <= tic_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // coarse count
  // ****************************************
  // gate reaches the chain only through the synchronizer
  tic_gate_sync u_gate_sync (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .gate_i(gate),
    .count_o(count_pulse)
  );

  // whole periods between the two events
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      coarse_count <= tic_pkg::COARSE_ZERO;
    end else if (state == tic_pkg::ST_IDLE) begin
      coarse_count <= tic_pkg::COARSE_ZERO;
    end else if (count_pulse && coarse_count != tic_pkg::COARSE_MAX) begin
      coarse_count <= coarse_count + 24'h000001;
    end
  end

  // ****************************************
  // fine counts
  // ****************************************
  // interpolator holds discharge 1000 times the residue
  // count clocks during the start discharge
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      start_fine_count <= tic_pkg::FINE_ZERO;
      start_fdone <= 1'b0;
    end else if (state == tic_pkg::ST_CALC) begin
      start_fine_count <= tic_pkg::FINE_ZERO;
      // a discharge ending in the clear cycle still sets: set wins
      start_fdone <= sdis_prev & ~sdis_ff[1];
    end else begin
      if (sdis_ff[1]) begin
        start_fine_count <= fine_inc(start_fine_count);
      end
      if (sdis_prev & ~sdis_ff[1]) begin
        start_fdone <= 1'b1;
      end
    end
  end

  // stop side mirrors the start side
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stop_fine_count <= tic_pkg::FINE_ZERO;
      stop_fdone <= 1'b0;
    end else if (state == tic_pkg::ST_CALC) begin
      stop_fine_count <= tic_pkg::FINE_ZERO;
      stop_fdone <= pdis_prev & ~pdis_ff[1];
    end else begin
      if (pdis_ff[1]) begin
        stop_fine_count <= fine_inc(stop_fine_count);
      end
      if (pdis_prev & ~pdis_ff[1]) begin
        stop_fdone <= 1'b1;
      end
    end
  end

  // arm lines tell each interpolator its event is still awaited
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      START_ARM_O <= 1'b0;
      STOP_ARM_O <= 1'b0;
      BUSY_O <= 1'b0;
    end else begin
      START_ARM_O <= (state == tic_pkg::ST_IDLE)
        || (gate && meas.coarse_neg);
      STOP_ARM_O <= (state == tic_pkg::ST_IDLE)
        || (gate && !meas.coarse_neg);
      BUSY_O <= (state != tic_pkg::ST_IDLE);
    end
  end

  // ****************************************
  // single-shot result
  // ****************************************
  logic signed [tic_pkg::RES_W-1:0] next_result;
  assign next_result = combine(meas);

  // one result unit is RESOLUTION_PS at the 10 MHz reference
  // RES_W holds COARSE_MAX*1000 plus fine range with sign
  // sign and magnitude beside the raw value
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      DONE_O <= 1'b0;
      RESULT_O <= tic_pkg::RES_ZERO;
      RESULT_NEG_O <= 1'b0;
      RESULT_MAG_O <= tic_pkg::RES_ZERO;
    end else begin
      DONE_O <= (state == tic_pkg::ST_CALC);
      if (state == tic_pkg::ST_CALC) begin
        RESULT_O <= next_result;
        RESULT_NEG_O <= next_result[tic_pkg::RES_W-1];
        RESULT_MAG_O <= next_result[tic_pkg::RES_W-1] ?
          -next_result : next_result;
      end
    end
  end

  // ****************************************
  // averaging
  // ****************************************
  // coarse only: the synchronizer count carries the averaged information
  logic signed [tic_pkg::ACC_W-1:0] acc;
  logic signed [tic_pkg::ACC_W-1:0] next_acc;
  logic [tic_pkg::AVG_CNT_W-1:0] avg_cnt;
  tic_pkg::tic_meas_t coarse_only;

  always_comb begin
    coarse_only = meas;
    coarse_only.start_fine = tic_pkg::FINE_ZERO;
    coarse_only.stop_fine = tic_pkg::FINE_ZERO;
    next_acc = acc + tic_pkg::ACC_W'(combine(coarse_only));
  end

  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      acc <= tic_pkg::ACC_ZERO;
      avg_cnt <= 8'h00;
      AVG_DONE_O <= 1'b0;
      AVG_RESULT_O <= tic_pkg::RES_ZERO;
    end else begin
      AVG_DONE_O <= 1'b0;
      if (!avg_ff[1]) begin
        acc <= tic_pkg::ACC_ZERO;
        avg_cnt <= 8'h00;
      end else if (state == tic_pkg::ST_CALC) begin
        if (avg_cnt == tic_pkg::AVG_LAST) begin
          AVG_RESULT_O <= tic_pkg::RES_W'(next_acc
            / $signed(tic_pkg::ACC_W'(tic_pkg::AVG_N)));
          AVG_DONE_O <= 1'b1;
          acc <= tic_pkg::ACC_ZERO;
          avg_cnt <= 8'h00;
        end else begin
          acc <= next_acc;
          avg_cnt <= avg_cnt + 8'h01;
        end
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence s_meas_close;
    state == tic_pkg::ST_FINE && fine_done;
  endsequence

  sequence s_calc_then_done;
    state == tic_pkg::ST_CALC ##1 DONE_O ##1 !BUSY_O;
  endsequence

  a_gate_pulse_len: assert property (
    gate |=> count_pulse) else $error("gated edge gave no full pulse");

  a_closed_gate_quiet: assert property (
    !gate |=> !count_pulse) else $error("count pulse with gate shut");

  a_coarse_step: assert property (
    state != tic_pkg::ST_IDLE && count_pulse
      && meas.coarse != tic_pkg::COARSE_MAX
    |=> meas.coarse == $past(meas.coarse) + 24'h000001)
    else $error("coarse count missed a pulse");

  a_start_fine_step: assert property (
    sdis_ff[1] && state != tic_pkg::ST_CALC && meas.start_fine < 11'h3E8
    |=> meas.start_fine == $past(meas.start_fine) + 11'h001)
    else $error("start fine count missed a cycle");

  a_stop_fine_step: assert property (
    pdis_ff[1] && state != tic_pkg::ST_CALC && meas.stop_fine < 11'h3E8
    |=> meas.stop_fine == $past(meas.stop_fine) + 11'h001)
    else $error("stop fine count missed a cycle");

  a_close_to_done: assert property (
    s_meas_close |=> s_calc_then_done)
    else $error("measurement did not complete in two cycles");

  a_zero_interval: assert property (
    state == tic_pkg::ST_IDLE && start_rise && stop_rise
    |=> state == tic_pkg::ST_FINE ##1 meas.coarse == tic_pkg::COARSE_ZERO)
    else $error("coincident events gave coarse count");

  a_sign_magnitude: assert property (
    DONE_O |-> RESULT_NEG_O == (RESULT_O < 0)
      && RESULT_MAG_O == (RESULT_NEG_O ? -RESULT_O : RESULT_O))
    else $error("sign or magnitude disagrees with result");

  a_sync_to_start: assert property (
    state == tic_pkg::ST_IDLE && $rose(start_ff[1])
    |=> state != tic_pkg::ST_IDLE) else $error("start edge not taken");

  a_avg_after_n: assert property (
    AVG_DONE_O |-> $past(avg_cnt) == tic_pkg::AVG_LAST
      && $past(state) == tic_pkg::ST_CALC)
    else $error("average posted at wrong count");

endmodule

// ---- bench/tic_trig_model.sv ----
// partner model: trigger pins and interpolator discharge levels
`timescale 1ns/1ps
module tic_trig_model (
  input wire logic clk_i,
  output logic start_o,
  output logic stop_o,
  output logic start_disch_o,
  output logic stop_disch_o
);
  initial begin
    start_o = 1'b0;
    stop_o = 1'b0;
    start_disch_o = 1'b0;
    stop_disch_o = 1'b0;
  end

  // ****************************************
  // one measurement: d > 0 start first, d < 0 stop first
  // ****************************************
  task automatic fire(input int d, input int n1, input int n2);
    int k;
    int ad;
    int m;
    ad = (d < 0) ? -d : d;
    for (k = 0; k <= ad; k++) begin
      @(posedge clk_i);
      #1;
      start_o = (d >= 0) || (k == ad);
      stop_o = (d <= 0) || (k == ad);
    end
    // held a little so both events pass the input flops
    repeat (3) @(posedge clk_i);
    #1;
    start_o = 1'b0;
    stop_o = 1'b0;
    m = (n1 > n2) ? n1 : n2;
    for (k = 0; k <= m; k++) begin
      @(posedge clk_i);
      #1;
      start_disch_o = (k < n1);
      stop_disch_o = (k < n2);
    end
  endtask
endmodule

// ---- bench/tic_top_tb.sv ----
// self-checking testbench of the interpolating interval counter
`timescale 1ns/1ps
module tic_top_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic avg_mode = 1'b0;
  logic start_w;
  logic stop_w;
  logic start_disch_w;
  logic stop_disch_w;
  logic start_arm;
  logic stop_arm;
  logic busy;
  logic done;
  logic signed [tic_pkg::RES_W-1:0] result;
  logic result_neg;
  logic [tic_pkg::RES_W-1:0] result_mag;
  logic avg_done;
  logic signed [tic_pkg::RES_W-1:0] avg_result;
  logic signed [tic_pkg::RES_W-1:0] exp_q[$];
  logic signed [tic_pkg::RES_W-1:0] avg_q[$];
  logic signed [tic_pkg::RES_W-1:0] e;
  logic [31:0] seed = 32'h06623FDF;
  int bad_count = 0;
  int tests_run = 0;
  int done_cnt = 0;
  longint sum;

  always #50 clk_i = ~clk_i;

  tic_trig_model u_trig (
    .clk_i(clk_i),
    .start_o(start_w),
    .stop_o(stop_w),
    .start_disch_o(start_disch_w),
    .stop_disch_o(stop_disch_w)
  );

  tic_top u_dut (
    .CLK_I(clk_i),
    .RESETN_I(resetn_i),
    .START_I(start_w),
    .STOP_I(stop_w),
    .START_DISCH_I(start_disch_w),
    .STOP_DISCH_I(stop_disch_w),
    .AVG_MODE_I(avg_mode),
    .START_ARM_O(start_arm),
    .STOP_ARM_O(stop_arm),
    .BUSY_O(busy),
    .DONE_O(done),
    .RESULT_O(result),
    .RESULT_NEG_O(result_neg),
    .RESULT_MAG_O(result_mag),
    .AVG_DONE_O(avg_done),
    .AVG_RESULT_O(avg_result)
  );

  // ****************************************
  // compare and report
  // ****************************************
  task automatic check_word(input string name,
                            input logic [tic_pkg::RES_W-1:0] exp,
                            input logic [tic_pkg::RES_W-1:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic check_bit(input string name, input logic exp,
                           input logic got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s exp %b got %b", name, exp, got);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // ****************************************
  // result watcher, sampled mid-cycle
  // ****************************************
  always @(negedge clk_i) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("unexpected done_o with no result pending");
      end else begin
        e = exp_q.pop_front();
        check_word("result_o", e, result);
        check_bit("result_neg_o", e[tic_pkg::RES_W-1], result_neg);
        check_word("result_mag_o", (e < 0) ? -e : e, result_mag);
      end
      done_cnt++;
    end
    if (avg_done === 1'b1) begin
      check_bit("avg_done_with_done", 1'b1, done);
      if (avg_q.size() == 0) begin
        bad_count++;
        $display("unexpected avg_done_o with no average pending");
      end else begin
        check_word("avg_result_o", avg_q.pop_front(), avg_result);
      end
    end
  end

  // fine counts saturate rather than wrap
  task automatic measure(input int d, input int n1, input int n2);
    longint x;
    int k;
    int i;
    x = longint'(d) * 1000 + ((n1 > 2047) ? 2047 : n1);
    x = x - ((n2 > 2047) ? 2047 : n2);
    exp_q.push_back(x[tic_pkg::RES_W-1:0]);
    k = done_cnt;
    u_trig.fire(d, n1, n2);
    for (i = 0; i < 200 && done_cnt == k; i++) begin
      @(posedge clk_i);
    end
    if (done_cnt == k) begin
      bad_count++;
      $display("unexpected missing done_o");
    end
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  initial begin
    #8000000;
    bad_count++;
    close_out();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check_bit("start_arm_o", 1'b1, start_arm);
    check_bit("stop_arm_o", 1'b1, stop_arm);
    check_bit("busy_o", 1'b0, busy);
    check_word("resolution_ps", 40'h0000000064,
               tic_pkg::RES_W'(tic_pkg::RESOLUTION_PS));
    measure(5, 100, 200);
    measure(-7, 300, 50);
    measure(0, 10, 10);
    measure(0, 1, 400);
    measure(1, 2100, 1);
    measure(-1, 1, 1);
    for (int i = 0; i < 20; i++) begin
      seed = xs(seed);
      measure(int'(seed[4:0]) - 16, int'(seed[15:8]) + 1,
              int'(seed[23:16]) + 1);
    end
    // averaging: 100 coarse results, truncated toward zero
    avg_mode = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    sum = 0;
    for (int i = 0; i < tic_pkg::AVG_N; i++) begin
      seed = xs(seed);
      sum = sum + (longint'(seed[4:0]) - 16) * 1000;
      if (i == tic_pkg::AVG_N - 1) begin
        avg_q.push_back(sum / tic_pkg::AVG_N);
      end
      measure(int'(seed[4:0]) - 16, int'(seed[12:8]) + 1,
              int'(seed[20:16]) + 1);
    end
    avg_mode = 1'b0;
    repeat (4) @(posedge clk_i);
    check_bit("avg_pending_empty", 1'b1, avg_q.size() == 0);
    close_out();
  end
endmodule
